/* File: hw/gsl_pkg.sv */
// Package of the genlock status and loop control block
// Assumes a 32-bit AXI4-Lite slave with one register per aligned word
`default_nettype none
package gsl_pkg;
    // ----------------------------------------
    // Register indices, byte address = 4 x index
    // ----------------------------------------
    localparam logic [5:0] IDX_STATUS = 6'h1f;
    localparam logic [5:0] IDX_LOOP = 6'h24;
    localparam logic [5:0] IDX_BW = 6'h26;
    localparam logic [5:0] IDX_IRQ_STS = 6'h30;
    localparam logic [5:0] IDX_IRQ_MASK = 6'h31;
    localparam int ADDR_W = 8;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int ST_HPOL = 4;
    localparam int ST_VPOL = 3;
    localparam int ST_BLANK = 2;
    localparam int ST_ALOCK = 1;
    localparam int ST_VLOCK = 0;
    localparam int IRQ_N = 4;
    localparam int IRQ_LOCK_UP = 0;
    localparam int IRQ_LOCK_DN = 1;
    localparam int IRQ_DISTURB = 2;
    localparam int IRQ_CRASH = 3;
    // ----------------------------------------
    // Bus answers and timing
    // ----------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int CRASH_MUL = 4;
    localparam int SYNC_N = 10;
    localparam logic [2:0] INIT_WAIT = 3'h4;
    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic present;
        logic h_pol;
        logic v_pol;
        logic digital_blank;
        logic blank_timing;
    } gsl_ref_t;
    typedef struct packed {
        logic [7:0] crash;
        logic [4:0] thr;
        logic [2:0] win;
        logic [5:0] bw;
    } gsl_loop_t;
    // Per-standard reset values of the loop fields
    localparam gsl_loop_t DEF_STD0 = '{8'h10, 5'h04, 3'h1, 6'h0a};
    localparam gsl_loop_t DEF_STD1 = '{8'h18, 5'h06, 3'h1, 6'h0c};
    localparam gsl_loop_t DEF_STD2 = '{8'h20, 5'h08, 3'h1, 6'h0e};
    localparam gsl_loop_t DEF_STD3 = '{8'h28, 5'h0a, 3'h1, 6'h10};
    typedef enum logic [2:0] {
        ACQ_IDLE = 3'h1,
        ACQ_CRASH = 3'h2,
        ACQ_TRACK = 3'h4
    } gsl_acq_t;
endpackage
`default_nettype wire

/* File: hw/gsl_top.sv */
// Genlock status, loop parameter registers, crash timer, lock and window logic
// Assumes detector and PLL levels arrive asynchronously on pins
`default_nettype none
module gsl_top
    import gsl_pkg::*;
#(
    parameter bit AUDIO_PRESENT = 1'b1
) (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic NRST,
    // AXI4-Lite slave
    input wire logic [ADDR_W-1:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [ADDR_W-1:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    // Reference detector and PLL pins
    input wire gsl_ref_t REF_IN,
    input wire logic H_REF,
    input wire logic VPLL_LOCK,
    input wire logic APLL_LOCK,
    input wire logic [1:0] STD_SEL,
    // Loop controls and indications
    output gsl_loop_t LOOP_CTRL,
    output logic CRASH_ACTIVE,
    output logic LOCK_IND,
    output logic REF_DISTURB,
    output logic IRQ
);
    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic [SYNC_N-1:0] raw, s1_q, s2_q, s3_q, st_q;
    assign raw = {STD_SEL, APLL_LOCK, VPLL_LOCK, H_REF, REF_IN};
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            st_q <= '0;
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (int i = 0; i < SYNC_N; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    st_q[i] <= s3_q[i];
                end
            end
        end
    end
    gsl_ref_t ref_s;
    logic h_s, h_old_q, h_edge, vl_s, al_s;
    logic [1:0] std_s;
    assign ref_s = st_q[4:0];
    assign h_s = st_q[5];
    assign vl_s = st_q[6];
    assign al_s = st_q[7];
    assign std_s = st_q[9:8];
    assign h_edge = h_s && !h_old_q;
    // ----------------------------------------
    // Loop registers and standard defaults
    // ----------------------------------------
    gsl_loop_t loop_q, def;
    logic [2:0] init_q;
    logic load;
    logic [IRQ_N-1:0] ev, sts_q, mask_q;
    logic wr_en;
    logic [5:0] wr_idx;
    logic [31:0] wd_q;
    always_comb begin
        unique case (std_s)
            2'h0: def = DEF_STD0;
            2'h1: def = DEF_STD1;
            2'h2: def = DEF_STD2;
            2'h3: def = DEF_STD3;
        endcase
    end
    assign load = (init_q == INIT_WAIT);
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            init_q <= '0;
        end else if (init_q <= INIT_WAIT) begin
            init_q <= init_q + 3'h1;
        end
    end
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            loop_q <= DEF_STD0;
        end else if (load) begin
            loop_q <= def;
        end else if (wr_en && wr_idx == IDX_LOOP) begin
            loop_q.crash <= wd_q[15:8];
            loop_q.thr <= wd_q[7:3];
            loop_q.win <= wd_q[2:0];
        end else if (wr_en && wr_idx == IDX_BW) begin
            loop_q.bw <= wd_q[5:0];
        end
    end
    assign LOOP_CTRL = loop_q;
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            mask_q <= '0;
        end else if (wr_en && wr_idx == IDX_IRQ_MASK) begin
            mask_q <= wd_q[IRQ_N-1:0];
        end
    end
    // ----------------------------------------
    // Crash lock sequencer
    // ----------------------------------------
    gsl_acq_t acq_q;
    logic [9:0] hcnt_q, crash_len;
    assign crash_len = 10'(CRASH_MUL * loop_q.crash + 1);
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            acq_q <= ACQ_IDLE;
            hcnt_q <= '0;
            h_old_q <= 1'b0;
        end else begin
            h_old_q <= h_s;
            if (!ref_s.present) begin
                acq_q <= ACQ_IDLE;
            end else begin
                unique case (acq_q)
                    ACQ_IDLE: begin
                        acq_q <= ACQ_CRASH;
                        hcnt_q <= '0;
                    end
                    ACQ_CRASH: begin
                        if (h_edge) begin
                            hcnt_q <= hcnt_q + 10'h1;
                            if (hcnt_q == crash_len - 10'h1) begin
                                acq_q <= ACQ_TRACK;
                            end
                        end
                    end
                    ACQ_TRACK: acq_q <= ACQ_TRACK;
                    default: acq_q <= ACQ_IDLE;
                endcase
            end
        end
    end
    assign CRASH_ACTIVE = (acq_q == ACQ_CRASH);
    // ----------------------------------------
    // Lock indication filter
    // ----------------------------------------
    logic lock_q;
    logic [5:0] lcnt_q;
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            lock_q <= 1'b0;
            lcnt_q <= '0;
        end else if (vl_s == lock_q) begin
            lcnt_q <= '0;
        end else if (h_edge || !vl_s) begin
            if (lcnt_q >= {1'b0, loop_q.thr}) begin
                lock_q <= vl_s;
                lcnt_q <= '0;
            end else if (h_edge) begin
                lcnt_q <= lcnt_q + 6'h1;
            end
        end
    end
    assign LOCK_IND = lock_q;
    // ----------------------------------------
    // Missing pulse window
    // ----------------------------------------
    logic [15:0] per_q, tmr_q;
    logic [3:0] miss_q;
    logic dist_q, expire;
    assign expire = !h_edge && per_q != '0 && tmr_q == per_q;
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            per_q <= '0;
            tmr_q <= '0;
            miss_q <= '0;
            dist_q <= 1'b0;
        end else if (h_edge) begin
            if (miss_q == '0) begin
                per_q <= tmr_q;
            end
            tmr_q <= '0;
            miss_q <= '0;
            dist_q <= 1'b0;
        end else if (expire) begin
            tmr_q <= '0;
            if (miss_q != 4'hf) begin
                miss_q <= miss_q + 4'h1;
            end
            if (miss_q >= {1'b0, loop_q.win}) begin
                dist_q <= 1'b1;
            end
        end else if (tmr_q != 16'hffff) begin
            tmr_q <= tmr_q + 16'h1;
        end
    end
    assign REF_DISTURB = dist_q;
    // ----------------------------------------
    // Interrupt status
    // ----------------------------------------
    logic lock_d1_q, dist_d1_q, crash_d1_q;
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            lock_d1_q <= 1'b0;
            dist_d1_q <= 1'b0;
            crash_d1_q <= 1'b0;
        end else begin
            lock_d1_q <= lock_q;
            dist_d1_q <= dist_q;
            crash_d1_q <= CRASH_ACTIVE;
        end
    end
    always_comb begin
        ev = '0;
        ev[IRQ_LOCK_UP] = lock_q && !lock_d1_q;
        ev[IRQ_LOCK_DN] = !lock_q && lock_d1_q;
        ev[IRQ_DISTURB] = dist_q && !dist_d1_q;
        ev[IRQ_CRASH] = !CRASH_ACTIVE && crash_d1_q;
    end
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            sts_q <= '0;
        end else if (wr_en && wr_idx == IDX_IRQ_STS) begin
            sts_q <= (sts_q & ~wd_q[IRQ_N-1:0]) | ev;
        end else begin
            sts_q <= sts_q | ev;
        end
    end
    assign IRQ = |(sts_q & mask_q);
    // ----------------------------------------
    // AXI4-Lite write path
    // ----------------------------------------
    logic aw_q, w_q, bv_q;
    logic [5:0] awi_q;
    logic [1:0] br_q;
    assign AWREADY = !aw_q && !bv_q;
    assign WREADY = !w_q && !bv_q;
    assign wr_en = aw_q && w_q && !bv_q;
    assign wr_idx = awi_q;
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            bv_q <= 1'b0;
            awi_q <= '0;
            wd_q <= '0;
            br_q <= RESP_OKAY;
        end else begin
            if (AWVALID && AWREADY) begin
                aw_q <= 1'b1;
                awi_q <= AWADDR[ADDR_W-1:2];
            end
            if (WVALID && WREADY) begin
                w_q <= 1'b1;
                wd_q <= WDATA;
            end
            if (wr_en) begin
                aw_q <= 1'b0;
                w_q <= 1'b0;
                bv_q <= 1'b1;
                unique case (awi_q)
                    IDX_STATUS, IDX_LOOP, IDX_BW, IDX_IRQ_STS, IDX_IRQ_MASK: br_q <= RESP_OKAY;
                    default: br_q <= RESP_SLVERR;
                endcase
            end else if (bv_q && BREADY) begin
                bv_q <= 1'b0;
            end
        end
    end
    assign BVALID = bv_q;
    assign BRESP = br_q;
    // ----------------------------------------
    // AXI4-Lite read path
    // ----------------------------------------
    logic rv_q;
    logic [31:0] rd_q, rmux;
    logic [1:0] rr_q, rresp;
    logic [5:0] ari;
    assign ari = ARADDR[ADDR_W-1:2];
    always_comb begin
        rmux = '0;
        rresp = RESP_OKAY;
        unique case (ari)
            IDX_STATUS: begin
                rmux[ST_HPOL] = ref_s.present && ref_s.h_pol;
                rmux[ST_VPOL] = ref_s.present && !ref_s.digital_blank && ref_s.v_pol;
                rmux[ST_BLANK] = ref_s.present && ref_s.blank_timing;
                rmux[ST_ALOCK] = AUDIO_PRESENT ? al_s : 1'b1;
                rmux[ST_VLOCK] = vl_s;
            end
            IDX_LOOP: rmux[15:0] = {loop_q.crash, loop_q.thr, loop_q.win};
            IDX_BW: rmux[5:0] = loop_q.bw;
            IDX_IRQ_STS: rmux[IRQ_N-1:0] = sts_q;
            IDX_IRQ_MASK: rmux[IRQ_N-1:0] = mask_q;
            default: rresp = RESP_SLVERR;
        endcase
    end
    assign ARREADY = !rv_q;
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            rv_q <= 1'b0;
            rd_q <= '0;
            rr_q <= RESP_OKAY;
        end else if (ARVALID && ARREADY) begin
            rv_q <= 1'b1;
            rd_q <= rmux;
            rr_q <= rresp;
        end else if (rv_q && RREADY) begin
            rv_q <= 1'b0;
        end
    end
    assign RVALID = rv_q;
    assign RDATA = rd_q;
    assign RRESP = rr_q;
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!NRST);
    logic st_rd;
    assign st_rd = ARVALID && ARREADY && ari == IDX_STATUS;
    property p_st_resv;
        st_rd |=> RDATA[31:5] == '0 && RVALID;
    endproperty
    a_st_resv: assert property (p_st_resv) else $error("status reserved bits set");
    property p_hpol;
        st_rd && !ref_s.present |=> !RDATA[ST_HPOL];
    endproperty
    a_hpol: assert property (p_hpol) else $error("H polarity without reference");
    property p_vpol;
        st_rd && (!ref_s.present || ref_s.digital_blank) |=> !RDATA[ST_VPOL];
    endproperty
    a_vpol: assert property (p_vpol) else $error("V polarity should read zero");
    property p_blank;
        st_rd && !ref_s.present |=> !RDATA[ST_BLANK];
    endproperty
    a_blank: assert property (p_blank) else $error("blank timing without reference");
    property p_alock;
        st_rd |=> RDATA[ST_ALOCK] == (AUDIO_PRESENT ? $past(al_s) : 1'b1);
    endproperty
    a_alock: assert property (p_alock) else $error("audio lock bit wrong");
    property p_vlock;
        st_rd |=> RDATA[ST_VLOCK] == $past(vl_s);
    endproperty
    a_vlock: assert property (p_vlock) else $error("video lock bit wrong");
    property p_crash;
        acq_q == ACQ_CRASH && ref_s.present && h_edge && hcnt_q == crash_len - 10'h1
            |=> acq_q == ACQ_TRACK && hcnt_q == 10'(CRASH_MUL * loop_q.crash + 1);
    endproperty
    a_crash: assert property (p_crash) else $error("crash period length wrong");
    property p_def;
        load |=> loop_q == $past(def);
    endproperty
    a_def: assert property (p_def) else $error("standard default not loaded");
    property p_thr;
        $changed(lock_q) |-> $past(lcnt_q) >= {1'b0, $past(loop_q.thr)};
    endproperty
    a_thr: assert property (p_thr) else $error("lock indication changed early");
    property p_win0;
        expire && loop_q.win == '0 |=> dist_q;
    endproperty
    a_win0: assert property (p_win0) else $error("zero window did not react");
    property p_win;
        expire && miss_q < {1'b0, loop_q.win} && !dist_q |=> !dist_q;
    endproperty
    a_win: assert property (p_win) else $error("disturbance inside window");
endmodule
`default_nettype wire

/* File: test/gsl_top_tb.sv */
// Self-checking testbench of the genlock status and loop control block
// Assumes gsl_pkg and gsl_top are compiled first; drives all pins itself
`default_nettype none
module gsl_top_tb
    import gsl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic sys_clk, nrst, awvalid, wvalid, bready, arvalid, rready, h_ref, vpll_lock, apll_lock;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rs, std_sel;
    logic awready, wready, bvalid, arready, rvalid;
    logic crash_active, lock_ind, ref_disturb, irq, dist_seen;
    gsl_ref_t ref_in;
    gsl_loop_t loop_ctrl, lp;
    gsl_loop_t defs [4];
    int miscompares, checked, hcnt;
    localparam logic [7:0] A_ST = {IDX_STATUS, 2'h0};
    localparam logic [7:0] A_LOOP = {IDX_LOOP, 2'h0};
    localparam logic [7:0] A_BW = {IDX_BW, 2'h0};
    localparam logic [7:0] A_IS = {IDX_IRQ_STS, 2'h0};
    localparam logic [7:0] A_IM = {IDX_IRQ_MASK, 2'h0};

    gsl_top gsl_top_inst (
        .SYS_CLK(sys_clk), .NRST(nrst),
        .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
        .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
        .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
        .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
        .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
        .REF_IN(ref_in), .H_REF(h_ref), .VPLL_LOCK(vpll_lock), .APLL_LOCK(apll_lock),
        .STD_SEL(std_sel), .LOOP_CTRL(loop_ctrl), .CRASH_ACTIVE(crash_active),
        .LOCK_IND(lock_ind), .REF_DISTURB(ref_disturb), .IRQ(irq)
    );

    always #20 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        if (ref_disturb === 1'b1) dist_seen = 1'b1;
    end
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] st_exp(gsl_ref_t r, logic a, logic v);
        logic [31:0] e;
        e = 32'h0;
        e[ST_HPOL] = r.present & r.h_pol;
        e[ST_VPOL] = r.present & !r.digital_blank & r.v_pol;
        e[ST_BLANK] = r.present & r.blank_timing;
        e[ST_ALOCK] = a;
        e[ST_VLOCK] = v;
        return e;
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        logic aw_ok;
        logic w_ok;
        n = 0;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok) && n < 50) begin
            @(posedge sys_clk);
            n++;
            if (awvalid && awready === 1'b1) begin
                awvalid <= 1'b0;
                aw_ok = 1'b1;
            end
            if (wvalid && wready === 1'b1) begin
                wvalid <= 1'b0;
                w_ok = 1'b1;
            end
        end
        do begin
            @(posedge sys_clk);
            n++;
        end while (bvalid !== 1'b1 && n < 100);
        r = bresp;
        bready <= 1'b0;
        chk(32'(bvalid), 32'h1);
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (arready !== 1'b1 && n < 50);
        arvalid <= 1'b0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (rvalid !== 1'b1 && n < 100);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        chk(32'(rvalid), 32'h1);
    endtask

    // One H reference pulse, period gap cycles
    task automatic hpulse(input int gap);
        @(posedge sys_clk);
        h_ref <= 1'b1;
        if (crash_active === 1'b1) hcnt++;
        repeat (2) @(posedge sys_clk);
        h_ref <= 1'b0;
        repeat (gap - 3) @(posedge sys_clk);
    endtask
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        sys_clk = 1'b0;
        nrst = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, h_ref, vpll_lock, apll_lock} = 8'h0;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hf;
        std_sel = 2'h0;
        ref_in = '0;
        miscompares = 0;
        checked = 0;
        void'($urandom(32'hdf64));
        defs = '{DEF_STD0, DEF_STD1, DEF_STD2, DEF_STD3};
        for (int s = 0; s < 4; s++) begin
            @(posedge sys_clk);
            std_sel <= 2'(s);
            nrst <= 1'b0;
            repeat (6) @(posedge sys_clk);
            nrst <= 1'b1;
            repeat (10) @(posedge sys_clk);
            axi_rd(A_LOOP, rd, rs);
            chk(rd, {16'h0, defs[s].crash, defs[s].thr, defs[s].win});
            chk(32'(rd[2:0]), 32'h1);
            axi_rd(A_BW, rd, rs);
            chk(rd, {26'h0, defs[s].bw});
            chk(32'(loop_ctrl), 32'(defs[s]));
        end
        for (int i = 0; i < 24; i++) begin
            @(posedge sys_clk);
            ref_in <= gsl_ref_t'($urandom);
            apll_lock <= 1'($urandom);
            vpll_lock <= 1'($urandom);
            repeat (6) @(posedge sys_clk);
            axi_rd(A_ST, rd, rs);
            chk(rd, st_exp(ref_in, apll_lock, vpll_lock));
        end
        axi_wr(A_ST, 32'hffffffff, rs);
        chk(32'(rs), 32'(RESP_OKAY));
        axi_rd(A_ST, rd, rs);
        chk(rd, st_exp(ref_in, apll_lock, vpll_lock));
        axi_rd(8'h80, rd, rs);
        chk(rd, 32'h0);
        chk(32'(rs), 32'(RESP_SLVERR));
        axi_wr(8'h94, 32'h0000ffff, rs);
        chk(32'(rs), 32'(RESP_SLVERR));
        for (int i = 0; i < 4; i++) begin
            lp.crash = 8'($urandom);
            lp.thr = 5'($urandom);
            lp.win = 3'($urandom);
            lp.bw = 6'(10 + $urandom_range(11));
            axi_wr(A_LOOP, {16'h0, lp.crash, lp.thr, lp.win}, rs);
            axi_wr(A_BW, {26'h0, lp.bw}, rs);
            axi_rd(A_LOOP, rd, rs);
            chk(rd, {16'h0, lp.crash, lp.thr, lp.win});
            axi_rd(A_BW, rd, rs);
            chk(rd, {26'h0, lp.bw});
            chk(32'(loop_ctrl), 32'(lp));
        end
        @(posedge sys_clk);
        ref_in <= '0;
        vpll_lock <= 1'b0;
        repeat (8) @(posedge sys_clk);
        axi_wr(A_LOOP, 32'h00000121, rs);
        axi_wr(A_IS, 32'h0000000f, rs);
        @(posedge sys_clk);
        ref_in <= gsl_ref_t'(5'h10);
        repeat (10) @(posedge sys_clk);
        chk(32'(crash_active), 32'h1);
        hcnt = 0;
        repeat (8) hpulse(20);
        chk(32'(hcnt), 32'h5);
        chk(32'(crash_active), 32'h0);
        chk(32'(irq), 32'h0);
        axi_wr(A_IM, 32'(1 << IRQ_CRASH), rs);
        repeat (2) @(posedge sys_clk);
        chk(32'(irq), 32'h1);
        axi_wr(A_IS, 32'(1 << IRQ_CRASH), rs);
        repeat (2) @(posedge sys_clk);
        chk(32'(irq), 32'h0);
        @(posedge sys_clk);
        vpll_lock <= 1'b1;
        repeat (3) hpulse(20);
        chk(32'(lock_ind), 32'h0);
        repeat (2) hpulse(20);
        chk(32'(lock_ind), 32'h1);
        for (int w = 1; w >= 0; w--) begin
            axi_wr(A_LOOP, {16'h0, 8'h01, 5'h04, 3'(w)}, rs);
            repeat (6) hpulse(20);
            dist_seen = 1'b0;
            hpulse(30);
            repeat (3) hpulse(20);
            chk(32'(dist_seen), 32'(w == 0));
        end
        @(posedge sys_clk);
        vpll_lock <= 1'b0;
        repeat (3) hpulse(20);
        chk(32'(lock_ind), 32'h1);
        repeat (2) hpulse(20);
        chk(32'(lock_ind), 32'h0);
        axi_rd(A_IS, rd, rs);
        chk(rd, 32'((1 << IRQ_LOCK_UP) | (1 << IRQ_LOCK_DN) | (1 << IRQ_DISTURB)));
        report_and_stop();
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        miscompares++;
        report_and_stop();
    end
endmodule
`default_nettype wire
